// [sim/sbcc_chk.sv]
`timescale 1ns/1ps
module sbcc_chk (
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [13:0] addr,
  input wire logic        dev_dq_oe_n,
  input wire logic [2:0]  mode_bl_in
);
  logic       ckp, sr;
  wire  [3:0] cmd  = {cs_n, ras_n, cas_n, we_n};
  wire        rd   = ckp && cmd == 4'h5;
  wire        acc  = ckp && cmd[3:1] == 3'h2;
  wire        bst  = ckp && cmd == 4'h6;
  wire        nop  = cs_n || cmd == 4'h7;
  wire        sref = ckp && !cke && cmd == 4'h1;
  // commands other than NOP only count when enable was high on the edge before
  always_ff @(posedge mclk_in or posedge rst_in)
    if (rst_in) {ckp, sr} <= 2'h0;
    else {ckp, sr} <= {cke, sref || (sr && !cke)};
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  a_stop_full_only: assert property (bst |-> mode_bl_in == 3'h7) else $error("bad stop");
  a_stop_release: assert property (bst |-> ##2 dev_dq_oe_n) else $error("dq held");
  a_ap_not_full: assert property (acc && mode_bl_in == 3'h7 |-> !addr[10]) else $error("ap");
  a_nop_keeps_burst:
    assert property (rd && mode_bl_in == 3'h2 ##1 nop [*3] |-> !dev_dq_oe_n [*3]) else $error("cut");
  a_sref_held: assert property (sref |=> !cke [*2]) else $error("sref cke");
  a_sref_quiet: assert property (sr |-> dev_dq_oe_n) else $error("sref dq");
  a_sref_exit: assert property (sr && cke |-> nop [*7]) else $error("sref exit");
  a_wake_nop: assert property ($rose(cke) |-> nop [*2]) else $error("wake cmd");
  cover property (bst);
  cover property (rd && addr[10]);
  cover property (sr && cke);
endmodule : sbcc_chk

// [sim/sdram_bank_command_control_tb.sv]
`timescale 1ns/1ps
module sdram_bank_command_control_tb;
  logic                  mclk_in = 1'b0, rst_in = 1'b1, rv = 1'b0, ap = 1'b0, il = 1'b0;
  logic                  rf, rvl, rdy, sro, pdo;
  logic [1:0]            bk = 2'h0;
  logic [2:0]            bl = 3'h2;
  logic [11:0]           ad = 12'h000;
  logic [7:0]            rdd, awd, lw, wd = 8'h00;
  logic                  aw;
  int                    nw = 0;
  logic [8:0]            col;
  logic [3:0]            bo;
  logic [7:0]            q[$];
  sbcc_pkg::sbcc_op_type op = sbcc_pkg::OP_NOP;
  int                    error_cnt = 0, checked = 0;
  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (rvl === 1'b1) q.push_back(rdd);
  always @(posedge mclk_in) begin
    if (aw === 1'b1) begin
      nw++;
      lw = awd;
    end
  end
  sbcc_if lnk();
  sbcc_host #(.REFRESH_PERIOD_CYC(50)) sbcc_host_i (.mclk_in, .rst_in, .link(lnk),
    .mode_bl_in(bl), .req_valid_in(rv), .req_op_in(op), .req_bank_in(bk), .req_addr_in(ad),
    .req_ap_in(ap), .wr_data_in(wd), .ready_out(rdy), .refused_out(rf),
    .wr_data_req_out(), .rd_valid_out(rvl), .rd_data_out(rdd), .self_refresh_out(),
    .power_down_out());
  // array model: data is a scramble of the column, so wrong columns show
  sbcc_device sbcc_device_i (.mclk_in, .rst_in, .link(lnk), .mode_cl_in(2'h2),
    .mode_bl_in(bl), .mode_interleave_in(il), .arr_rdata_in(col[7:0] ^ 8'h3c),
    .arr_rd_out(), .arr_wr_out(aw), .arr_bank_out(), .arr_col_out(col), .arr_wdata_out(awd),
    .bank_open_out(bo), .precharge_out(), .self_refresh_out(sro), .power_down_out(pdo));
  sbcc_chk sbcc_chk_i (.mclk_in, .rst_in, .cke(lnk.cke), .cs_n(lnk.cs_n), .ras_n(lnk.ras_n),
    .cas_n(lnk.cas_n), .we_n(lnk.we_n), .addr(lnk.addr), .dev_dq_oe_n(lnk.dev_dq_oe_n),
    .mode_bl_in(bl));
  function automatic logic [8:0] ec(logic [8:0] s, int k, logic [2:0] b, logic i);
    logic [8:0] m;
    m = (b == 3'h7) ? 9'h1ff : 9'((1 << b) - 1);
    return i ? s ^ (9'(k) & m) : (s & ~m) | ((s + 9'(k)) & m);
  endfunction : ec
  task automatic ck(string n, logic [8:0] e, logic [8:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : ck
  task automatic rq(sbcc_pkg::sbcc_op_type o, logic [11:0] a, logic p);
    op = o;
    ad = a;
    ap = p;
    rv = 1'b1;
    do @(posedge mclk_in); while (rdy !== 1'b1);
    @(negedge mclk_in) rv = 1'b0;
  endtask : rq
  task automatic rdt(logic [2:0] b, logic p, logic [8:0] c);
    logic [8:0] e;
    bl = b;
    il = 1'($urandom);
    bk = 2'($urandom);
    rq(sbcc_pkg::OP_ACT, 12'($urandom), 1'b0);
    repeat (6) @(negedge mclk_in);
    q.delete();
    rq(sbcc_pkg::OP_READ, {3'h0, c}, p);
    repeat (6) @(negedge mclk_in);
    rq(sbcc_pkg::OP_BST, 12'h000, 1'b0);
    if (b != 3'h7) ck("stop refused", 9'h1, {8'h0, rf});
    repeat (10) @(negedge mclk_in);
    ck("beats", (b == 3'h7) ? 9'h7 : 9'(1 << b), 9'(q.size()));
    foreach (q[k]) begin
      e = ec(c, k, b, il);
      ck("data", {1'b0, e[7:0] ^ 8'h3c}, {1'b0, q[k]});
    end
    ck("open", {8'h0, !p}, {8'h0, bo[bk]});
    if (!p) rq(sbcc_pkg::OP_PRE, 12'h000, 1'b0);
    repeat (8) @(negedge mclk_in);
    ck("closed", 9'h0, {5'h0, bo});
    $display("read test done");
  endtask : rdt
  // full page is stopped after seven beats, later host data must not land
  task automatic wrt(logic [2:0] b, logic p);
    bl = b;
    bk = 2'($urandom);
    wd = 8'($urandom);
    rq(sbcc_pkg::OP_ACT, 12'($urandom), 1'b0);
    repeat (6) @(negedge mclk_in);
    nw = 0;
    rq(sbcc_pkg::OP_WRITE, 12'($urandom), p);
    repeat (6) @(negedge mclk_in);
    if (b == 3'h7) rq(sbcc_pkg::OP_BST, 12'h000, 1'b0);
    repeat (10) @(negedge mclk_in);
    ck("writes", (b == 3'h7) ? 9'h7 : 9'(1 << b), 9'(nw));
    ck("wdata", {1'b0, wd}, {1'b0, lw});
    ck("wr open", {8'h0, !p}, {8'h0, bo[bk]});
    if (!p) rq(sbcc_pkg::OP_PRE, 12'h000, 1'b0);
    repeat (8) @(negedge mclk_in);
    ck("wr closed", 9'h0, {5'h0, bo});
    $display("write test done");
  endtask : wrt
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  initial begin
    #100us;
    error_cnt++;
    wrap_up();
  end
  initial begin
    void'($urandom(64653));
    repeat (10) @(negedge mclk_in);
    rst_in = 1'b0;
    rdt(3'h7, 1'b0, 9'h1fd);
    for (int k = 0; k < 12; k++) begin
      logic [2:0] b;
      b = (k % 4 == 3) ? 3'h7 : 3'(k % 4 + 1);
      rdt(b, b != 3'h7 && 1'($urandom), 9'($urandom));
    end
    for (int k = 0; k < 4; k++) begin
      logic [2:0] b;
      b = (k == 3) ? 3'h7 : 3'(k + 1);
      wrt(b, b != 3'h7 && 1'($urandom));
    end
    bk = 2'h0;
    rq(sbcc_pkg::OP_ACT, 12'h0a5, 1'b0);
    bk = 2'h2;
    rq(sbcc_pkg::OP_ACT, 12'h15a, 1'b0);
    repeat (3) @(negedge mclk_in);
    ck("two open", 9'h5, {5'h0, bo});
    rq(sbcc_pkg::OP_PRE_ALL, 12'h400, 1'b0);
    repeat (4) @(negedge mclk_in);
    ck("all closed", 9'h0, {5'h0, bo});
    for (int m = 0; m < 2; m++) begin
      rq(m ? sbcc_pkg::OP_PDOWN : sbcc_pkg::OP_SREF, 12'h000, 1'b0);
      repeat (4) @(negedge mclk_in);
      ck("low power", 9'h1, {8'h0, m ? pdo : sro});
      rq(sbcc_pkg::OP_WAKE, 12'h000, 1'b0);
      repeat (12) @(negedge mclk_in);
      ck("awake", 9'h0, {8'h0, sro | pdo});
      $display("low power test done");
    end
    wrap_up();
  end
endmodule : sdram_bank_command_control_tb

// [verilog/sbcc_burst_addr.sv]
`timescale 1ns/1ps
module sbcc_burst_addr (
  input  wire logic [sbcc_pkg::COL_W-1:0] start_in,
  input  wire logic [sbcc_pkg::COL_W-1:0] beat_in,
  input  wire logic [2:0]                 bl_in,
  input  wire logic                       interleave_in,
  output logic      [sbcc_pkg::COL_W-1:0] col_out
);
  logic [sbcc_pkg::COL_W-1:0] mask;
  logic [sbcc_pkg::COL_W-1:0] seq_col;

  assign mask    = sbcc_pkg::sbcc_burst_mask(bl_in);
  // no carry out of the masked field
  assign seq_col = (start_in & ~mask) | ((start_in + beat_in) & mask);
  assign col_out = interleave_in ? (start_in ^ (beat_in & mask)) : seq_col;
endmodule : sbcc_burst_addr

// [verilog/sbcc_device.sv]
`timescale 1ns/1ps
module sbcc_device (
  input  wire logic                        mclk_in,
  input  wire logic                        rst_in,
  sbcc_if.device                           link,
  input  wire logic [1:0]                  mode_cl_in,
  input  wire logic [2:0]                  mode_bl_in,
  input  wire logic                        mode_interleave_in,
  input  wire logic [sbcc_pkg::DATA_W-1:0] arr_rdata_in,
  output logic                             arr_rd_out,
  output logic                             arr_wr_out,
  output logic [sbcc_pkg::BANK_W-1:0]      arr_bank_out,
  output logic [sbcc_pkg::COL_W-1:0]       arr_col_out,
  output logic [sbcc_pkg::DATA_W-1:0]      arr_wdata_out,
  output logic [sbcc_pkg::BANKS-1:0]       bank_open_out,
  output logic                             precharge_out,
  output logic                             self_refresh_out,
  output logic                             power_down_out
);
  localparam int PIPE = sbcc_pkg::CL_MAX - 2;

  typedef enum logic [1:0] {DEV_RUN, DEV_SREF, DEV_PDOWN} sbcc_dev_mode_type;

  typedef struct packed {
    sbcc_dev_mode_type                         mode;
    logic                                      cke_q;
    logic [sbcc_pkg::BANKS-1:0]                open;
    logic                                      busy;
    logic                                      wr;
    logic                                      ap;
    logic [sbcc_pkg::BANK_W-1:0]               bank;
    logic [sbcc_pkg::COL_W-1:0]                start;
    logic [sbcc_pkg::COL_W-1:0]                beat;
    logic [1:0]                                rec_cnt;
    logic [sbcc_pkg::BANK_W-1:0]               rec_bank;
    logic [PIPE-1:0]                           pv;
    logic [PIPE-1:0][sbcc_pkg::DATA_W-1:0]     pd;
    logic [sbcc_pkg::DATA_W-1:0]               dq;
    logic                                      dq_oe_n;
    logic                                      arr_rd;
    logic                                      arr_wr;
    logic [sbcc_pkg::BANK_W-1:0]               arr_bank;
    logic [sbcc_pkg::COL_W-1:0]                arr_col;
    logic [sbcc_pkg::DATA_W-1:0]               arr_wdata;
    logic                                      pre;
  } sbcc_dev_state_type;

  localparam sbcc_dev_state_type RESET_STATE = '{mode: DEV_RUN, dq_oe_n: 1'b1, default: '0};

  sbcc_dev_state_type          r;
  sbcc_dev_state_type          next_r;
  sbcc_pkg::sbcc_cmd_type      cmd;
  logic [sbcc_pkg::BANK_W-1:0] cbank;
  logic [sbcc_pkg::COL_W-1:0]  ccol;
  logic [sbcc_pkg::COL_W-1:0]  mask;
  logic [sbcc_pkg::COL_W-1:0]  col_now;
  logic                        full;
  logic                        run;

  assign cmd   = link.cs_n ? sbcc_pkg::CMD_NOP
               : sbcc_pkg::sbcc_cmd_type'({link.ras_n, link.cas_n, link.we_n});
  assign cbank = link.addr[sbcc_pkg::BANK_LSB +: sbcc_pkg::BANK_W];
  assign ccol  = link.addr[sbcc_pkg::COL_W-1:0];
  assign mask  = sbcc_pkg::sbcc_burst_mask(mode_bl_in);
  assign full  = (mode_bl_in == sbcc_pkg::BL_FULL);
  // enable low on the previous edge freezes bursts and command decode (suspend)
  assign run   = (r.mode == DEV_RUN) && r.cke_q;

  sbcc_burst_addr u_addr (
    .start_in      (r.start),
    .beat_in       (r.beat),
    .bl_in         (mode_bl_in),
    .interleave_in (mode_interleave_in),
    .col_out       (col_now)
  );

  always_comb begin
    logic [sbcc_pkg::BANKS-1:0] clr;
    logic [sbcc_pkg::BANKS-1:0] set;
    clr = '0;
    set = '0;
    next_r = r;
    next_r.cke_q = link.cke;
    next_r.arr_rd = 1'b0;
    next_r.arr_wr = 1'b0;

    // read data path: array word of this cycle, then PIPE stages
    next_r.pv[0] = r.arr_rd;
    next_r.pd[0] = arr_rdata_in;
    for (int i = 1; i < PIPE; i++) begin
      next_r.pv[i] = r.pv[i-1];
      next_r.pd[i] = r.pd[i-1];
    end
    next_r.dq_oe_n = ~r.arr_rd;
    next_r.dq = arr_rdata_in;
    for (int i = 0; i < PIPE; i++) begin
      if (int'(mode_cl_in) == i + 3) begin
        next_r.dq_oe_n = ~r.pv[i];
        next_r.dq = r.pd[i];
      end
    end

    // write recovery before the automatic precharge
    if (r.rec_cnt != 2'h0) begin
      next_r.rec_cnt = r.rec_cnt - 2'h1;
      if (r.rec_cnt == 2'h1) begin
        clr[r.rec_bank] = 1'b1;
      end
    end

    // burst beats after the first; NOP and deselect leave this alone
    if (run && r.busy) begin
      next_r.arr_bank = r.bank;
      next_r.arr_col = col_now;
      next_r.beat = r.beat + 9'h001;
      if (r.wr) begin
        next_r.arr_wr = 1'b1;
        next_r.arr_wdata = link.dq;
      end else begin
        next_r.arr_rd = 1'b1;
      end
      if (!full && r.beat == mask) begin
        next_r.busy = 1'b0;
        if (r.ap && r.wr) begin
          next_r.rec_cnt = 2'(sbcc_pkg::WRITE_RECOVERY_CYC);
          next_r.rec_bank = r.bank;
        end else if (r.ap) begin
          // last array read: precharge leads the last data by the latency
          clr[r.bank] = 1'b1;
        end
      end
    end

    if (run) begin
      case (cmd)
        sbcc_pkg::CMD_BST: begin
          // row stays open; beat of this edge is neither read nor written
          next_r.busy = 1'b0;
          next_r.arr_rd = 1'b0;
          next_r.arr_wr = 1'b0;
        end
        sbcc_pkg::CMD_READ, sbcc_pkg::CMD_WRITE: begin
          next_r.wr = (cmd == sbcc_pkg::CMD_WRITE);
          next_r.ap = link.addr[sbcc_pkg::AP_BIT];
          next_r.bank = cbank;
          next_r.start = ccol;
          next_r.beat = 9'h001;
          next_r.busy = full || (mask != 9'h000);
          next_r.arr_bank = cbank;
          next_r.arr_col = ccol;
          next_r.arr_rd = (cmd == sbcc_pkg::CMD_READ);
          next_r.arr_wr = (cmd == sbcc_pkg::CMD_WRITE);
          next_r.arr_wdata = link.dq;
          if (link.addr[sbcc_pkg::AP_BIT] && !full && mask == 9'h000) begin
            if (cmd == sbcc_pkg::CMD_WRITE) begin
              next_r.rec_cnt = 2'(sbcc_pkg::WRITE_RECOVERY_CYC);
              next_r.rec_bank = cbank;
            end else begin
              clr[cbank] = 1'b1;
            end
          end
        end
        sbcc_pkg::CMD_PRE: begin
          if (link.addr[sbcc_pkg::AP_BIT]) begin
            clr = '1;
          end else begin
            clr[cbank] = 1'b1;
          end
          if (clr[r.bank]) begin
            next_r.busy = 1'b0;
          end
        end
        sbcc_pkg::CMD_ACT: begin
          set[cbank] = 1'b1;
        end
        sbcc_pkg::CMD_REF: begin
          if (!link.cke) begin
            next_r.mode = DEV_SREF;
            next_r.busy = 1'b0;
          end
        end
        sbcc_pkg::CMD_NOP: begin
          if (!link.cke && !r.busy) begin
            next_r.mode = DEV_PDOWN;
          end
        end
        default: begin
        end
      endcase
    end else if (r.mode != DEV_RUN) begin
      // only the enable pin is looked at here
      if (link.cke) begin
        next_r.mode = DEV_RUN;
      end
    end

    next_r.open = (r.open | set) & ~clr;
    next_r.pre = |clr;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= RESET_STATE;
    end else begin
      r <= next_r;
    end
  end

  assign link.dev_dq      = r.dq;
  assign link.dev_dq_oe_n = r.dq_oe_n;
  assign arr_rd_out       = r.arr_rd;
  assign arr_wr_out       = r.arr_wr;
  assign arr_bank_out     = r.arr_bank;
  assign arr_col_out      = r.arr_col;
  assign arr_wdata_out    = r.arr_wdata;
  assign bank_open_out    = r.open;
  assign precharge_out    = r.pre;
  assign self_refresh_out = (r.mode == DEV_SREF);
  assign power_down_out   = (r.mode == DEV_PDOWN);
endmodule : sbcc_device

// [verilog/sbcc_host.sv]
`timescale 1ns/1ps
module sbcc_host #(
  parameter int REFRESH_PERIOD_CYC = 100000
) (
  input  wire logic                        mclk_in,
  input  wire logic                        rst_in,
  sbcc_if.host                             link,
  input  wire logic [2:0]                  mode_bl_in,
  input  wire logic                        req_valid_in,
  input  wire sbcc_pkg::sbcc_op_type       req_op_in,
  input  wire logic [sbcc_pkg::BANK_W-1:0] req_bank_in,
  input  wire logic [sbcc_pkg::ROW_W-1:0]  req_addr_in,
  input  wire logic                        req_ap_in,
  input  wire logic [sbcc_pkg::DATA_W-1:0] wr_data_in,
  output logic                             ready_out,
  output logic                             refused_out,
  output logic                             wr_data_req_out,
  output logic                             rd_valid_out,
  output logic [sbcc_pkg::DATA_W-1:0]      rd_data_out,
  output logic                             self_refresh_out,
  output logic                             power_down_out
);
  localparam int LP_W = $clog2(REFRESH_PERIOD_CYC + 1);
  localparam int TW   = sbcc_pkg::TIMER_W;

  typedef enum logic [1:0] {HOST_RUN, HOST_SREF, HOST_PDOWN} sbcc_host_mode_type;

  typedef struct packed {
    sbcc_host_mode_type                mode;
    logic                              cke;
    logic                              cs_n;
    sbcc_pkg::sbcc_cmd_type            cmd;
    logic [sbcc_pkg::ADDR_W-1:0]       addr;
    logic [sbcc_pkg::DATA_W-1:0]       dq;
    logic                              dq_oe_n;
    logic                              ready;
    logic                              refused;
    logic [sbcc_pkg::COL_W-1:0]        wleft;
    logic                              wfull;
    logic                              wreq;
    logic                              fp_busy;
    logic [TW-1:0]                     ap_cnt;
    logic [sbcc_pkg::BANKS-1:0]        open;
    logic [sbcc_pkg::BANKS-1:0][TW-1:0] bank_wait;
    logic [sbcc_pkg::BANKS-1:0][TW-1:0] ras_wait;
    logic [TW-1:0]                     wake_cnt;
    logic [LP_W-1:0]                   lp_cnt;
    logic                              rd_valid;
    logic [sbcc_pkg::DATA_W-1:0]       rd_data;
  } sbcc_host_state_type;

  localparam sbcc_host_state_type RESET_STATE = '{mode: HOST_RUN, cke: 1'b1, cs_n: 1'b1,
    cmd: sbcc_pkg::CMD_NOP, dq_oe_n: 1'b1, default: '0};

  sbcc_host_state_type        r;
  sbcc_host_state_type        next_r;
  logic [sbcc_pkg::COL_W-1:0] mask;
  logic                       full;
  logic                       streaming;
  logic                       idle_banks;

  assign mask      = sbcc_pkg::sbcc_burst_mask(mode_bl_in);
  assign full      = (mode_bl_in == sbcc_pkg::BL_FULL);
  assign streaming = (r.wleft != 9'h000) || r.wfull;

  always_comb begin
    idle_banks = (r.open == '0);
    for (int i = 0; i < sbcc_pkg::BANKS; i++) begin
      idle_banks = idle_banks && (r.bank_wait[i] == '0);
    end
  end

  always_comb begin
    logic ok;
    ok = 1'b0;
    next_r = r;
    next_r.cs_n = 1'b0;
    next_r.cmd = sbcc_pkg::CMD_NOP;
    next_r.refused = 1'b0;
    next_r.dq_oe_n = 1'b1;
    next_r.rd_valid = !link.dev_dq_oe_n;
    next_r.rd_data = link.dq;
    for (int i = 0; i < sbcc_pkg::BANKS; i++) begin
      if (r.bank_wait[i] != '0) next_r.bank_wait[i] = r.bank_wait[i] - 8'h01;
      if (r.ras_wait[i] != '0) next_r.ras_wait[i] = r.ras_wait[i] - 8'h01;
    end
    if (r.ap_cnt != '0) next_r.ap_cnt = r.ap_cnt - 8'h01;
    if (r.wake_cnt != '0) next_r.wake_cnt = r.wake_cnt - 8'h01;
    if (streaming) begin
      next_r.dq = wr_data_in;
      next_r.dq_oe_n = 1'b0;
      if (!r.wfull) next_r.wleft = r.wleft - 9'h001;
    end

    case (r.mode)
      HOST_RUN: begin
        if (r.ready && req_valid_in) begin
          case (req_op_in)
            sbcc_pkg::OP_NOP: ok = 1'b1;
            sbcc_pkg::OP_ACT:
              ok = !r.open[req_bank_in] && r.bank_wait[req_bank_in] == '0 && !streaming;
            sbcc_pkg::OP_READ, sbcc_pkg::OP_WRITE:
              ok = r.open[req_bank_in] && r.ap_cnt == '0 && !streaming
                && !(req_ap_in && (full || r.ras_wait[req_bank_in] != '0));
            sbcc_pkg::OP_PRE, sbcc_pkg::OP_PRE_ALL: ok = r.ap_cnt == '0 && !streaming;
            sbcc_pkg::OP_BST: ok = r.fp_busy;
            sbcc_pkg::OP_SREF: ok = idle_banks && r.ap_cnt == '0 && !streaming;
            sbcc_pkg::OP_PDOWN: ok = r.ap_cnt == '0 && !streaming && !r.fp_busy;
            default: ok = 1'b0;
          endcase
          next_r.refused = !ok;
        end
        if (ok) begin
          next_r.addr = {req_bank_in, req_addr_in};
          case (req_op_in)
            sbcc_pkg::OP_ACT: begin
              next_r.cmd = sbcc_pkg::CMD_ACT;
              next_r.open[req_bank_in] = 1'b1;
              next_r.ras_wait[req_bank_in] = TW'(sbcc_pkg::ACT_TO_PRE_CYC);
            end
            sbcc_pkg::OP_READ, sbcc_pkg::OP_WRITE: begin
              next_r.addr = {req_bank_in, 1'b0, req_ap_in, 1'b0,
                             req_addr_in[sbcc_pkg::COL_W-1:0]};
              next_r.fp_busy = full;
              if (req_op_in == sbcc_pkg::OP_WRITE) begin
                next_r.cmd = sbcc_pkg::CMD_WRITE;
                next_r.dq = wr_data_in;
                next_r.dq_oe_n = 1'b0;
                next_r.wleft = mask;
                next_r.wfull = full;
              end else begin
                next_r.cmd = sbcc_pkg::CMD_READ;
              end
              if (req_ap_in) begin
                next_r.open[req_bank_in] = 1'b0;
                if (req_op_in == sbcc_pkg::OP_WRITE) begin
                  next_r.ap_cnt = TW'(mask) + TW'(1 + sbcc_pkg::WRITE_RECOVERY_CYC);
                  next_r.bank_wait[req_bank_in] =
                    TW'(mask) + TW'(sbcc_pkg::DATAIN_TO_ACTIVATE_CYC);
                end else begin
                  next_r.ap_cnt = TW'(mask) + 8'h01;
                  next_r.bank_wait[req_bank_in] = TW'(mask) + TW'(sbcc_pkg::PRECHARGE_CYC);
                end
              end
            end
            sbcc_pkg::OP_PRE, sbcc_pkg::OP_PRE_ALL: begin
              next_r.cmd = sbcc_pkg::CMD_PRE;
              next_r.addr[sbcc_pkg::AP_BIT] = (req_op_in == sbcc_pkg::OP_PRE_ALL);
              next_r.fp_busy = 1'b0;
              for (int i = 0; i < sbcc_pkg::BANKS; i++) begin
                if (req_op_in == sbcc_pkg::OP_PRE_ALL || i == int'(req_bank_in)) begin
                  next_r.open[i] = 1'b0;
                  next_r.bank_wait[i] = TW'(sbcc_pkg::PRECHARGE_CYC);
                end
              end
            end
            sbcc_pkg::OP_BST: begin
              next_r.cmd = sbcc_pkg::CMD_BST;
              next_r.fp_busy = 1'b0;
              next_r.wfull = 1'b0;
              next_r.wleft = '0;
              next_r.dq_oe_n = 1'b1;
            end
            sbcc_pkg::OP_SREF: begin
              next_r.cmd = sbcc_pkg::CMD_REF;
              next_r.cke = 1'b0;
              next_r.mode = HOST_SREF;
            end
            sbcc_pkg::OP_PDOWN: begin
              next_r.cke = 1'b0;
              next_r.mode = HOST_PDOWN;
              next_r.lp_cnt = '0;
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        next_r.cke = 1'b0;
        if (r.mode == HOST_PDOWN) next_r.lp_cnt = r.lp_cnt + 1'b1;
        // leave power down before any row could lose its charge
        if ((r.ready && req_valid_in && req_op_in == sbcc_pkg::OP_WAKE)
            || (r.mode == HOST_PDOWN && r.lp_cnt == LP_W'(REFRESH_PERIOD_CYC - 1))) begin
          next_r.cke = 1'b1;
          next_r.mode = HOST_RUN;
          next_r.wake_cnt = (r.mode == HOST_SREF) ? TW'(sbcc_pkg::SREF_EXIT_CYC)
                          : TW'(sbcc_pkg::ENABLE_SETUP_CYC);
        end else if (r.ready && req_valid_in) begin
          next_r.refused = 1'b1;
        end
      end
    endcase
    next_r.ready = (next_r.wake_cnt == '0);
    next_r.wreq = (next_r.wleft != 9'h000) || next_r.wfull;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= RESET_STATE;
    end else begin
      r <= next_r;
    end
  end

  assign link.cke          = r.cke;
  assign link.cs_n         = r.cs_n;
  assign link.ras_n        = r.cmd[2];
  assign link.cas_n        = r.cmd[1];
  assign link.we_n         = r.cmd[0];
  assign link.addr         = r.addr;
  assign link.host_dq      = r.dq;
  assign link.host_dq_oe_n = r.dq_oe_n;
  assign ready_out         = r.ready;
  assign refused_out       = r.refused;
  assign wr_data_req_out   = r.wreq;
  assign rd_valid_out      = r.rd_valid;
  assign rd_data_out       = r.rd_data;
  assign self_refresh_out  = (r.mode == HOST_SREF);
  assign power_down_out    = (r.mode == HOST_PDOWN);
endmodule : sbcc_host

// [verilog/sbcc_if.sv]
`timescale 1ns/1ps
interface sbcc_if;
  logic                         cke;
  logic                         cs_n;
  logic                         ras_n;
  logic                         cas_n;
  logic                         we_n;
  logic [sbcc_pkg::ADDR_W-1:0]  addr;
  logic [sbcc_pkg::DATA_W-1:0]  host_dq;
  logic                         host_dq_oe_n;
  logic [sbcc_pkg::DATA_W-1:0]  dev_dq;
  logic                         dev_dq_oe_n;
  logic [sbcc_pkg::DATA_W-1:0]  dq;

  // host wins a clash; both driving is a fault of the host anyway
  assign dq = !host_dq_oe_n ? host_dq : (!dev_dq_oe_n ? dev_dq : 8'h00);

  modport host (
    output cke, cs_n, ras_n, cas_n, we_n, addr, host_dq, host_dq_oe_n,
    input  dq, dev_dq_oe_n
  );
  modport device (
    input  cke, cs_n, ras_n, cas_n, we_n, addr, dq,
    output dev_dq, dev_dq_oe_n
  );
endinterface : sbcc_if

// [verilog/sbcc_pkg.sv]
package sbcc_pkg;
  localparam int ADDR_W   = 14;
  localparam int DATA_W   = 8;
  localparam int COL_W    = 9;
  localparam int ROW_W    = 12;
  localparam int BANK_W   = 2;
  localparam int BANKS    = 4;
  localparam int AP_BIT   = 10;
  localparam int BANK_LSB = 12;
  localparam int CL_MAX   = 3;
  localparam int TIMER_W  = 8;

  // burst_length codes as held in the mode setting
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;

  // times in their own unit, plain defaults
  localparam int CLK_PERIOD_PS      = 10000;
  localparam int PRECHARGE_NS       = 20;
  localparam int ACT_TO_PRE_NS      = 45;
  localparam int ROW_CYCLE_NS       = 65;
  localparam int SREF_EXIT_NS       = 10;
  localparam int ENABLE_SETUP_NS    = 2;
  localparam int WRITE_RECOVERY_CYC = 1;

  localparam int PRECHARGE_CYC  = (PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACT_TO_PRE_CYC = (ACT_TO_PRE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SREF_EXIT_CYC  =
    ((ROW_CYCLE_NS + SREF_EXIT_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // enable_setup_period plus one minimum clock period
  localparam int ENABLE_SETUP_CYC =
    (ENABLE_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  localparam int DATAIN_TO_ACTIVATE_CYC = WRITE_RECOVERY_CYC + PRECHARGE_CYC;

  // order follows the {ras_n, cas_n, we_n} pin pattern
  typedef enum logic [2:0] {
    CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WRITE, CMD_READ, CMD_BST, CMD_NOP
  } sbcc_cmd_type;

  typedef enum logic [3:0] {
    OP_NOP, OP_ACT, OP_READ, OP_WRITE, OP_BST, OP_PRE, OP_PRE_ALL, OP_SREF, OP_PDOWN, OP_WAKE
  } sbcc_op_type;

  function automatic logic [COL_W-1:0] sbcc_burst_mask(input logic [2:0] bl);
    case (bl)
      BL_2:    return 9'h001;
      BL_4:    return 9'h003;
      BL_8:    return 9'h007;
      BL_FULL: return 9'h1ff;
      default: return 9'h000;
    endcase
  endfunction : sbcc_burst_mask
endpackage : sbcc_pkg
